// File: common/powerup_pkg.sv
// Constants, encodings and timing for the power-up mode sequencer
package powerup_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ     = 200_000_000;
  localparam int unsigned MS_PER_S   = 1000;
  localparam int unsigned TICK_CYC   = CLK_HZ / MS_PER_S;
  localparam int unsigned ACTIVE_S   = 3;
  localparam int unsigned PASSIVE_S  = 7;
  localparam int unsigned QUERY_S    = 30;
  localparam int unsigned PROBE_MS   = 1000;
  localparam logic [14:0] ACTIVE_MS  = 15'(ACTIVE_S * MS_PER_S);
  localparam logic [14:0] PASSIVE_MS = 15'(PASSIVE_S * MS_PER_S);
  localparam logic [14:0] QUERY_MS   = 15'(QUERY_S * MS_PER_S);
  localparam logic [14:0] PROBE_TMO  = 15'(PROBE_MS);

  // ==========================================================
  // Status LED codes
  localparam logic [3:0] LED_INIT    = 4'hF;
  localparam logic [3:0] LED_ENTER   = 4'hE;
  localparam logic [3:0] LED_POK     = 4'hD;
  localparam logic [3:0] LED_GRP_LO  = 4'h4;
  localparam logic [3:0] LED_LOOP    = 4'h6;
  localparam logic [3:0] LED_CONSOLE = 4'h3;
  localparam logic [3:0] LED_PRIMARY = 4'h2;
  localparam logic [3:0] LED_SECOND  = 4'h1;
  localparam logic [3:0] LED_OS      = 4'h0;

  // ==========================================================
  // Countdown, language selection
  localparam logic [5:0] STEP_FIRST   = 6'h3E;
  localparam logic [5:0] STEP_LAST    = 6'h03;
  localparam logic [5:0] STEP_PER_GRP = 6'h07;
  localparam logic [3:0] LANG_DEFAULT = 4'h5;
  localparam logic [4:0] LANG_MIN     = 5'h01;
  localparam logic [4:0] LANG_MAX     = 5'h0F;

  // ==========================================================
  // Console characters
  localparam logic [7:0] CHR_ESC  = 8'h1B;
  localparam logic [7:0] CHR_LBR  = 8'h5B;
  localparam logic [7:0] CHR_QM   = 8'h3F;
  localparam logic [7:0] CHR_C    = 8'h63;
  localparam logic [7:0] CHR_SIX  = 8'h36;
  localparam logic [7:0] CHR_ZERO = 8'h30;
  localparam logic [7:0] CHR_NINE = 8'h39;
  localparam logic [7:0] CHR_CR   = 8'h0D;
  localparam logic [7:0] CHR_GT   = 8'h3E;
  localparam logic [7:0] LOOP_A   = 8'h55;
  localparam logic [7:0] LOOP_B   = 8'hAA;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_QUERY  = 2'b01,
    MODE_TEST   = 2'b10
  } mode_t;

  typedef enum logic [1:0] {
    MSG_PROBE  = 2'b00,
    MSG_LOOP   = 2'b01,
    MSG_CDOWN  = 2'b10,
    MSG_PROMPT = 2'b11
  } msg_t;

  typedef enum logic [3:0] {
    ST_INIT     = 4'b0000,
    ST_ENTER    = 4'b0001,
    ST_WAIT_POK = 4'b0010,
    ST_MODE     = 4'b0011,
    ST_LOOP_ACT = 4'b0100,
    ST_LOOP_PAS = 4'b0101,
    ST_HANG     = 4'b0110,
    ST_PROBE_RX = 4'b0111,
    ST_QUERY    = 4'b1000,
    ST_DIAG_LED = 4'b1001,
    ST_DIAG_RUN = 4'b1010,
    ST_DUMP     = 4'b1011,
    ST_DIAG_NXT = 4'b1100,
    ST_CONSOLE  = 4'b1101,
    ST_BOOT     = 4'b1110,
    ST_SEND     = 4'b1111
  } state_t;

endpackage : powerup_pkg

// File: logic/powerup_mode_sequencer.sv
// Power-up sequencer: console probe, mode branch, diagnostics countdown, boot
`timescale 1ns/1ps

module powerup_mode_sequencer #(
  parameter int unsigned TICK_CYCLES = powerup_pkg::TICK_CYC
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               power_good,
  input  wire powerup_pkg::mode_t mode_switch,
  input  wire logic [3:0]         baud_switch,
  input  wire logic               battery_failed,
  input  wire logic               halt_enable,
  input  wire logic               boot_cmd,
  input  wire logic               auto_boot_halt,
  input  wire logic               boot_failed,
  input  wire logic               second_stage,
  input  wire logic               os_started,
  output logic [7:0]              tx_data,
  output logic                    tx_valid,
  input  wire logic               tx_ready,
  input  wire logic [7:0]         rx_data,
  input  wire logic               rx_valid,
  input  wire logic               rx_error,
  output logic                    diag_start,
  output logic [5:0]              diag_test,
  input  wire logic               diag_done,
  input  wire logic               diag_fail,
  output logic                    dump_req,
  input  wire logic               dump_done,
  output logic [3:0]              module_led,
  output logic [3:0]              panel_led,
  output logic [3:0]              baud_sel,
  output logic                    hardcopy,
  output logic                    multinational_charset,
  output logic                    query_active,
  output logic [3:0]              language,
  output logic                    console_mode,
  output logic                    boot_start
);
  import powerup_pkg::*;

  if (TICK_CYCLES < 1 || TICK_CYCLES > 2**18) begin : g_chk
    $error("TICK_CYCLES must lie between one and the prescaler range");
  end

  // ==========================================================
  // Functions
  function automatic logic [7:0] tx_byte(msg_t m, logic [1:0] i, logic [5:0] s);
    logic [7:0] r;
    r = CHR_GT;
    case (m)
      MSG_PROBE:  r = (i == 2'd0) ? CHR_ESC : (i == 2'd1) ? CHR_LBR : CHR_C;
      MSG_LOOP:   r = (i == 2'd0) ? LOOP_A : LOOP_B;
      MSG_CDOWN:  r = CHR_ZERO + 8'((i == 2'd0) ? s / 6'd10 : s % 6'd10);
      default:    r = CHR_GT;
    endcase
    return r;
  endfunction : tx_byte

  function automatic logic [1:0] msg_last(msg_t m);
    logic [1:0] r;
    case (m)
      MSG_PROBE:  r = 2'd2;
      MSG_LOOP:   r = 2'd1;
      MSG_CDOWN:  r = 2'd1;
      default:    r = 2'd2;
    endcase
    return r;
  endfunction : msg_last

  function automatic logic [3:0] grp_led(logic [5:0] s);
    return LED_GRP_LO + 4'((s - STEP_LAST) / STEP_PER_GRP);
  endfunction : grp_led

  // ==========================================================
  // State
  state_t      state_q;
  state_t      prev_q;
  state_t      ret_q;
  mode_t       mode_q;
  msg_t        msg_q;
  logic [1:0]  idx_q;
  logic [17:0] pre_q;
  logic        tick_q;
  logic [14:0] ms_q;
  logic [5:0]  step_q;
  logic        fail_q;
  logic        rx_seen_q;
  logic [2:0]  pidx_q;
  logic        pok_q;
  logic [4:0]  sel_q;
  logic [3:0]  led_q;

  assign module_led = led_q;

  // ==========================================================
  // Millisecond prescaler and phase timer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pre_q  <= '0;
      tick_q <= 1'b0;
    end else if (pre_q >= 18'(TICK_CYCLES - 1)) begin
      pre_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      pre_q  <= pre_q + 18'd1;
      tick_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prev_q <= ST_INIT;
      ms_q   <= '0;
    end else begin
      prev_q <= state_q;
      // A step's timer starts with its message, so its traffic counts toward the phase
      if (prev_q != state_q && prev_q != ST_SEND)
        ms_q <= '0;
      else if (tick_q && ms_q != 15'h7FFF)
        ms_q <= ms_q + 15'd1;
    end
  end

  // Panel copy follows the module LED register one cycle later
  always_ff @(posedge clk) begin
    if (!resetn)
      panel_led <= LED_INIT;
    else
      panel_led <= (state_q == ST_INIT) ? LED_INIT : led_q;
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q               <= ST_INIT;
      ret_q                 <= ST_INIT;
      mode_q                <= MODE_NORMAL;
      msg_q                 <= MSG_PROBE;
      idx_q                 <= '0;
      step_q                <= STEP_FIRST;
      fail_q                <= 1'b0;
      rx_seen_q             <= 1'b0;
      pidx_q                <= '0;
      pok_q                 <= 1'b0;
      sel_q                 <= '0;
      led_q                 <= LED_INIT;
      tx_data               <= '0;
      tx_valid              <= 1'b0;
      diag_start            <= 1'b0;
      diag_test             <= STEP_FIRST;
      dump_req              <= 1'b0;
      baud_sel              <= '0;
      hardcopy              <= 1'b0;
      multinational_charset <= 1'b0;
      query_active          <= 1'b0;
      language              <= LANG_DEFAULT;
      console_mode          <= 1'b0;
      boot_start            <= 1'b0;
    end else begin
      diag_start <= 1'b0;
      dump_req   <= 1'b0;
      boot_start <= 1'b0;
      case (state_q)
        ST_INIT: begin
          led_q   <= LED_ENTER;
          state_q <= ST_ENTER;
        end
        ST_ENTER: begin
          led_q   <= LED_POK;
          state_q <= ST_WAIT_POK;
        end
        ST_WAIT_POK: if (power_good) begin
          mode_q  <= mode_switch;
          state_q <= ST_MODE;
        end
        ST_MODE: begin
          idx_q <= '0;
          if (mode_q == MODE_TEST) begin
            led_q    <= LED_LOOP;
            baud_sel <= baud_switch;
            msg_q    <= MSG_LOOP;
            ret_q    <= ST_LOOP_ACT;
          end else begin
            msg_q <= MSG_PROBE;
            ret_q <= ST_PROBE_RX;
          end
          rx_seen_q <= 1'b0;
          pidx_q    <= '0;
          pok_q     <= 1'b1;
          state_q   <= ST_SEND;
        end
        ST_LOOP_ACT: begin
          if (rx_valid)
            rx_seen_q <= 1'b1;
          if (rx_error) begin
            state_q <= ST_HANG;
          end else if (ms_q >= ACTIVE_MS) begin
            if (!rx_seen_q && !rx_valid) begin
              state_q <= ST_HANG;
            end else begin
              led_q   <= LED_CONSOLE;
              state_q <= ST_LOOP_PAS;
            end
          end
        end
        ST_LOOP_PAS: begin
          if (rx_error)
            state_q <= ST_HANG;
          else if (ms_q >= PASSIVE_MS) begin
            // Re-sampling here picks the next phase: another active phase in test mode, else the console probe
            mode_q  <= mode_switch;
            state_q <= ST_MODE;
          end
        end
        ST_HANG: led_q <= LED_LOOP;
        ST_PROBE_RX: begin
          if (rx_valid) begin
            pidx_q <= (pidx_q == 3'd7) ? pidx_q : pidx_q + 3'd1;
            case (pidx_q)
              3'd0: pok_q <= pok_q & (rx_data == CHR_ESC);
              3'd1: pok_q <= pok_q & (rx_data == CHR_LBR);
              3'd2: pok_q <= pok_q & (rx_data == CHR_QM);
              3'd3: multinational_charset <= (rx_data == CHR_SIX);
              default: ;
            endcase
          end
          if (rx_valid && rx_data == CHR_C && pidx_q >= 3'd4) begin
            hardcopy <= !pok_q;
            if (!pok_q)
              multinational_charset <= 1'b0;
            if (pok_q && multinational_charset &&
                (mode_q == MODE_QUERY || battery_failed)) begin
              query_active <= 1'b1;
              sel_q        <= '0;
              state_q      <= ST_QUERY;
            end else begin
              language <= LANG_DEFAULT;
              step_q   <= STEP_FIRST;
              state_q  <= ST_DIAG_LED;
            end
          end else if (ms_q >= PROBE_TMO) begin
            hardcopy              <= 1'b1;
            multinational_charset <= 1'b0;
            language              <= LANG_DEFAULT;
            step_q                <= STEP_FIRST;
            state_q               <= ST_DIAG_LED;
          end
        end
        ST_QUERY: begin
          if (ms_q >= QUERY_MS) begin
            language     <= LANG_DEFAULT;
            query_active <= 1'b0;
            step_q       <= STEP_FIRST;
            state_q      <= ST_DIAG_LED;
          end else if (rx_valid && rx_data >= CHR_ZERO && rx_data <= CHR_NINE) begin
            // A digit after a value above 2 would give 30 or more, so saturate
            sel_q <= (sel_q > 5'd2) ? 5'h1F : 5'(sel_q * 5'd10 + 5'(rx_data - CHR_ZERO));
          end else if (rx_valid && rx_data == CHR_CR) begin
            if (sel_q >= LANG_MIN && sel_q <= LANG_MAX) begin
              language     <= sel_q[3:0];
              query_active <= 1'b0;
              step_q       <= STEP_FIRST;
              state_q      <= ST_DIAG_LED;
            end else
              sel_q <= '0;
          end
        end
        ST_DIAG_LED: begin
          led_q   <= grp_led(step_q);
          state_q <= ST_DIAG_RUN;
        end
        ST_DIAG_RUN: begin
          if (prev_q != ST_DIAG_RUN) begin
            diag_start <= 1'b1;
            diag_test  <= step_q;
          end else if (diag_done) begin
            idx_q <= '0;
            msg_q <= MSG_CDOWN;
            ret_q <= ST_DIAG_NXT;
            if (diag_fail) begin
              fail_q   <= 1'b1;
              dump_req <= 1'b1;
              state_q  <= ST_DUMP;
            end else
              state_q <= ST_SEND;
          end
        end
        ST_DUMP: if (dump_done) state_q <= ST_SEND;
        ST_DIAG_NXT: begin
          idx_q <= '0;
          if (step_q != STEP_LAST) begin
            step_q  <= step_q - 6'd1;
            state_q <= ST_DIAG_LED;
          end else if (!fail_q && !halt_enable) begin
            led_q      <= LED_PRIMARY;
            boot_start <= 1'b1;
            state_q    <= ST_BOOT;
          end else begin
            led_q   <= LED_CONSOLE;
            msg_q   <= MSG_PROMPT;
            ret_q   <= ST_CONSOLE;
            state_q <= ST_SEND;
          end
        end
        ST_CONSOLE: begin
          console_mode <= 1'b1;
          if (boot_cmd || auto_boot_halt) begin
            console_mode <= 1'b0;
            led_q        <= LED_PRIMARY;
            boot_start   <= 1'b1;
            state_q      <= ST_BOOT;
          end
        end
        ST_BOOT: begin
          if (boot_failed) begin
            led_q   <= LED_CONSOLE;
            idx_q   <= '0;
            msg_q   <= MSG_PROMPT;
            ret_q   <= ST_CONSOLE;
            state_q <= ST_SEND;
          end else if (os_started)
            led_q <= LED_OS;
          else if (second_stage)
            led_q <= LED_SECOND;
        end
        ST_SEND: begin
          if (!tx_valid) begin
            tx_data  <= tx_byte(msg_q, idx_q, step_q);
            tx_valid <= 1'b1;
          end else if (tx_ready) begin
            tx_valid <= 1'b0;
            if (idx_q == msg_last(msg_q))
              state_q <= ret_q;
            else
              idx_q <= idx_q + 2'd1;
          end
        end
        default: state_q <= ST_INIT;
      endcase
    end
  end

endmodule : powerup_mode_sequencer

// File: testbench/powerup_props.sv
// Concurrent checks on the power-up sequencer ports
`timescale 1ns/1ps
module powerup_props
  import powerup_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 1
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       power_good,
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic       diag_start,
  input wire logic [5:0] diag_test,
  input wire logic [3:0] module_led,
  input wire logic [3:0] panel_led,
  input wire logic       hardcopy,
  input wire logic       multinational_charset,
  input wire logic       query_active,
  input wire logic       console_mode,
  input wire logic       boot_start
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ==========================================================
  // Properties
  property p_panel; panel_led == $past(module_led); endproperty
  a_panel: assert property (p_panel) else $error("panel code differs from module code");
  property p_wake; $rose(resetn) |-> module_led == LED_INIT ##1 module_led == LED_ENTER ##1 module_led == LED_POK;
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up code order wrong");
  property p_diag; diag_start |-> diag_test inside {[3:62]} && module_led == 4'(4 + (diag_test - 3) / 7); endproperty
  a_diag: assert property (p_diag) else $error("test group code not shown at test start");
  property p_boot; boot_start |-> module_led == LED_PRIMARY ##1 !boot_start; endproperty
  a_boot: assert property (p_boot) else $error("boot start without loader code");
  property p_cons; $rose(console_mode) |-> module_led == LED_CONSOLE; endproperty
  a_cons: assert property (p_cons) else $error("console mode without code 3");
  property p_tx; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
  a_tx: assert property (p_tx) else $error("console byte dropped before taken");
  property p_query; query_active |-> multinational_charset && !hardcopy; endproperty
  a_query: assert property (p_query) else $error("language query without charset");
  property p_hard; hardcopy |-> !multinational_charset; endproperty
  a_hard: assert property (p_hard) else $error("hardcopy console marked with charset");
  // No console byte or diagnostic test may start while supply is still settling
  property p_gate; !power_good && module_led == LED_POK |-> !tx_valid && !diag_start; endproperty
  a_gate: assert property (p_gate) else $error("activity before power good");
endmodule : powerup_props

bind powerup_mode_sequencer powerup_props #(.TICK_CYCLES(TICK_CYCLES)) u_powerup_props (
  .clk, .resetn, .power_good, .tx_data, .tx_valid, .tx_ready, .diag_start, .diag_test, .module_led, .panel_led,
  .hardcopy, .multinational_charset, .query_active, .console_mode, .boot_start);

// File: testbench/console_term.sv
// Console terminal model: attribute reply, loopback echo, typed keys
`timescale 1ns/1ps
module console_term (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic [1:0] reply,
  input  wire logic       echo,
  input  wire logic       slow
);
  logic [7:0] q[$];
  logic [7:0] ans[5];
  logic [7:0] b;
  logic       take;

  task automatic send(input logic [7:0] c);
    q.push_back(c);
  endtask : send

  // ==========================================================
  // Terminal side, changes just after each edge
  initial begin
    tx_ready = 1'b1;
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    forever begin
      @(posedge clk);
      take = tx_valid & tx_ready;
      b = tx_data;
      #1;
      if (!resetn) q.delete();
      if (take && echo) q.push_back(b);
      // Digit 6 in the reply marks the extended character set
      if (take && b == 8'h63 && reply != 2'h0) begin
        ans = '{8'h1B, 8'h5B, 8'h3F, (reply == 2'h1) ? 8'h36 : 8'h31, 8'h63};
        foreach (ans[i]) q.push_back(ans[i]);
      end
      tx_ready = slow ? ~tx_ready : 1'b1;
      // Idle line alternates between the inverted and the true last byte
      rx_data = ~rx_data;
      if (rx_valid) rx_valid = 1'b0;
      else if (q.size() != 0) begin
        rx_data = q.pop_front();
        rx_valid = 1'b1;
      end
    end
  end
endmodule : console_term

// File: testbench/tb_top.sv
// Self-checking bench for the power-up mode sequencer
`timescale 1ns/1ps
module tb_top;
  import powerup_pkg::*;
  typedef struct packed {
    mode_t m; logic [1:0] rep; logic bat, halt; logic [5:0] fail; logic [7:0] k0, k1;
    logic hc, cs, qa, con; logic [3:0] lang;
  } row_t;
  logic clk, resetn, power_good, battery_failed, halt_enable, boot_cmd, auto_boot_halt, boot_failed;
  logic second_stage, os_started, tx_valid, tx_ready, rx_valid, rx_error, diag_start, diag_done, diag_fail;
  logic dump_req, dump_done, hardcopy, multinational_charset, query_active, console_mode, boot_start, echo, slow, f;
  mode_t      mode_switch;
  logic [7:0] tx_data, rx_data;
  logic [5:0] diag_test, fail_at, exp_test;
  logic [3:0] baud_switch, module_led, panel_led, baud_sel, language;
  logic [1:0] reply;
  int         errors, check_count, cyc, ndump, nq, nb, act, pas;
  logic [7:0] dq[$];
  row_t rows[7] = '{
    '{MODE_NORMAL, 1, 0, 1, 0, 0, 0, 0, 1, 0, 1, 5}, '{MODE_NORMAL, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 5},
    '{MODE_QUERY, 1, 0, 1, 0, "1", "2", 0, 1, 1, 1, 12}, '{MODE_NORMAL, 1, 1, 1, 0, "7", 0, 0, 1, 1, 1, 7},
    '{MODE_QUERY, 2, 0, 1, 0, 0, 0, 0, 0, 0, 1, 5}, '{MODE_NORMAL, 1, 0, 0, 10, 0, 0, 0, 1, 0, 1, 5},
    '{MODE_QUERY, 1, 0, 1, 0, "1", "6", 0, 1, 1, 1, 5}};
  row_t trow = '{MODE_TEST, 1, 0, 1, 0, 0, 0, 0, 1, 0, 1, 5};
  row_t qrow = '{MODE_QUERY, 1, 0, 1, 0, 0, 0, 0, 1, 1, 1, 5};

  powerup_mode_sequencer #(.TICK_CYCLES(1)) u_powerup_mode_sequencer (
    .clk, .resetn, .power_good, .mode_switch, .baud_switch, .battery_failed, .halt_enable, .boot_cmd,
    .auto_boot_halt, .boot_failed, .second_stage, .os_started, .tx_data, .tx_valid, .tx_ready, .rx_data,
    .rx_valid, .rx_error, .diag_start, .diag_test, .diag_done, .diag_fail, .dump_req, .dump_done, .module_led,
    .panel_led, .baud_sel, .hardcopy, .multinational_charset, .query_active, .language, .console_mode, .boot_start);
  console_term u_console_term (.clk, .resetn, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .reply, .echo,
    .slow);

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk

  task automatic wrap_up();
    $display("Counts: %0d compared, %0d mismatched", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic start(input row_t r);
    mode_switch = r.m;
    reply = r.rep;
    battery_failed = r.bat;
    halt_enable = r.halt;
    fail_at = r.fail;
    slow = r.bat | r.qa;
    power_good = 1'b0;
    resetn = 1'b0;
    repeat (12) tick();
    resetn = 1'b1;
    repeat (20) tick();
    chk("wait_led", module_led, LED_POK);
    chk("panel", panel_led, LED_POK);
    chk("idle_tx", tx_valid, 0);
    dq.delete();
    ndump = 0;
    nq = 0;
    nb = 0;
    exp_test = STEP_FIRST;
    power_good = 1'b1;
  endtask : start

  task automatic finish(input row_t r);
    bit typed;
    typed = 0;
    for (int n = 0; n < 40000 && console_mode !== 1'b1 && boot_start !== 1'b1; n++) begin
      if (query_active === 1'b1 && !typed) begin
        typed = 1;
        if (r.k0 != 8'h00) u_console_term.send(r.k0);
        if (r.k1 != 8'h00) u_console_term.send(r.k1);
        if (r.k0 != 8'h00) u_console_term.send(CHR_CR);
      end
      tick();
    end
    chk("hardcopy", hardcopy, r.hc);
    chk("charset", multinational_charset, r.cs);
    chk("queried", nq != 0, r.qa);
    chk("language", language, r.lang);
    chk("console", console_mode, r.con);
    chk("end_led", module_led, r.con ? LED_CONSOLE : LED_PRIMARY);
    chk("dumps", ndump, r.fail != 6'h00);
    chk("digits", dq.size(), 120);
    chk("ends", {dq[0], dq[1], dq[118], dq[119]}, {CHR_SIX, 8'h32, CHR_ZERO, 8'h33});
  endtask : finish

  task automatic kick(ref logic s, input logic [3:0] led);
    s = 1'b1;
    tick();
    s = 1'b0;
    repeat (10) tick();
    chk("kick_led", module_led, led);
  endtask : kick

  // ==========================================================
  // Diagnostic responder; a slow dump exposes a skipped wait
  initial forever begin
    @(posedge clk);
    if (diag_start) begin
      f = (diag_test == fail_at);
      #1;
      repeat (2) tick();
      diag_done = 1'b1;
      diag_fail = f;
      tick();
      diag_done = 1'b0;
      diag_fail = 1'b0;
    end else if (dump_req) begin
      #1;
      repeat (3) tick();
      dump_done = 1'b1;
      tick();
      dump_done = 1'b0;
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tx_valid && tx_ready && tx_data inside {[CHR_ZERO:CHR_NINE]}) dq.push_back(tx_data);
    if (query_active) nq <= nq + 1;
    if (dump_req) ndump <= ndump + 1;
    if (boot_start) nb <= nb + 1;
    if (diag_start) begin
      chk("step", diag_test, exp_test);
      exp_test <= exp_test - 6'h01;
    end
    if (cyc == 90000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    {resetn, power_good, battery_failed, halt_enable, boot_cmd, auto_boot_halt, boot_failed} = 7'h00;
    {second_stage, os_started, rx_error, diag_done, diag_fail, dump_done, echo, slow} = 8'h00;
    mode_switch = MODE_NORMAL;
    {baud_switch, reply, fail_at, cyc, errors, check_count} = '0;
    foreach (rows[i]) begin
      start(rows[i]);
      finish(rows[i]);
      $display("row %0d done", i);
    end
    kick(boot_cmd, LED_PRIMARY);
    kick(boot_failed, LED_CONSOLE);
    kick(auto_boot_halt, LED_PRIMARY);
    chk("boots", nb, 2);
    kick(second_stage, LED_SECOND);
    kick(os_started, LED_OS);
    $display("boot steps done");
    baud_switch = 4'hA;
    echo = 1'b1;
    start(trow);
    for (int n = 0; n < 100 && module_led !== LED_LOOP; n++) tick();
    for (act = 0; module_led === LED_LOOP && act < 5000; act++) tick();
    chk("baud", baud_sel, 4'hA);
    chk("active", (act + 5) / 10, 300);
    mode_switch = MODE_NORMAL;
    echo = 1'b0;
    // LED 3 also covers the probe that follows, so stop at its first byte
    for (pas = 0; module_led === LED_CONSOLE && tx_valid !== 1'b1 && pas < 9000; pas++) tick();
    chk("passive", (pas + 5) / 10, 700);
    finish(trow);
    $display("loopback done");
    echo = 1'b1;
    start(trow);
    repeat (100) tick();
    rx_error = 1'b1;
    tick();
    rx_error = 1'b0;
    repeat (3100) tick();
    chk("error_led", module_led, LED_LOOP);
    $display("error loopback done");
    echo = 1'b0;
    start(trow);
    repeat (3100) tick();
    chk("hang_led", module_led, LED_LOOP);
    $display("silent loopback done");
    start(qrow);
    finish(qrow);
    chk("query_time", (nq + 5) / 10, 3000);
    $display("query timeout done");
    wrap_up();
  end
endmodule : tb_top
